/* hdl/current_b_config_regs.sv */
// Configuration, calibration and conversion pacing for current channel B.
// Assumes a register port already decoded from SPI frames and a modulator tick strobe.
module current_b_config_regs (
    input wire logic i_clock, // System clock, 50 MHz.
    input wire logic i_rst, // Synchronous register reset, active high.
    input wire logic i_reg_write, // Register write strobe.
    input wire logic i_reg_read, // Register read strobe.
    input wire logic [7:0] i_reg_addr, // Register address.
    input wire logic [15:0] i_reg_wdata, // Register write data.
    input wire logic i_mod_tick, // One pulse per modulator period.
    input wire logic i_standby, // Device in standby.
    input wire logic i_power_down, // Device in power-down.
    input wire logic i_start, // Start pulse for single-shot mode.
    input wire logic [23:0] i_raw_sample, // Filter output before offset and digital gain.
    output logic [15:0] o_reg_rdata, // Read data, valid the cycle after a read.
    output logic o_reg_rvalid, // Read data strobe.
    output logic o_channel_on, // Channel enabled and powered.
    output logic o_single_shot, // Single-shot mode selected.
    output logic o_chop_on, // Global chop active.
    output logic o_chop_settling, // Inside the chop delay after a chop swap.
    output logic [1:0] o_analog_gain, // Analog gain code, 4 or 8.
    output logic [1:0] o_route, // Input route code.
    output logic o_source_on_negative, // Test source on the negative pin.
    output logic o_sink_on_negative, // Test sink on the negative pin.
    output logic [1:0] o_source_magnitude, // Test source current code.
    output logic [1:0] o_sink_magnitude, // Test sink current code.
    output logic [23:0] o_result, // Corrected conversion result.
    output logic o_result_valid, // Pulse when a new result is stored.
    output logic [1:0] o_conversion_counter // Two-bit conversion counter.
);
    typedef enum logic [1:0] {IDLE, CONVERT, CHOP_WAIT} phase_e;

    typedef struct packed {
        phase_e phase;
        logic chop_phase;
        logic [23:0] result;
        logic result_valid;
        logic [1:0] counter;
        logic [15:0] rdata;
        logic rvalid;
        logic channel_on;
        logic single_shot;
        logic chop_on;
        logic chop_settling;
        logic [1:0] analog_gain;
        logic [1:0] route;
        logic source_neg;
        logic sink_neg;
        logic [1:0] source_mag;
        logic [1:0] sink_mag;
    } state_s;

    state_s state;
    state_s next_state;
    logic [15:0] config_one;
    logic [15:0] config_two;
    logic [15:0] offset_upper;
    logic [15:0] offset_lower;
    logic wr_one;
    logic wr_two;
    logic wr_upper;
    logic wr_lower;
    logic channel_active;
    logic conv_done;
    logic chop_done;
    logic [4:0] osr_log2;
    logic [4:0] chop_log2;
    logic signed [23:0] offset_value;
    logic signed [23:0] corrected;
    logic [1:0] gain_code;
    logic [23:0] gained;

    assign wr_one = i_reg_write && i_reg_addr == current_b_pkg::ADDR_CONFIG_ONE;
    assign wr_two = i_reg_write && i_reg_addr == current_b_pkg::ADDR_CONFIG_TWO;
    assign wr_upper = i_reg_write && i_reg_addr == current_b_pkg::ADDR_OFFSET_UPPER;
    assign wr_lower = i_reg_write && i_reg_addr == current_b_pkg::ADDR_OFFSET_LOWER;

    current_b_reg16 #(
        .RESET_VALUE(current_b_pkg::RESET_CONFIG_ONE),
        .WRITE_MASK(current_b_pkg::MASK_CONFIG_ONE)
    ) u_config_one (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(wr_one),
        .i_data(i_reg_wdata),
        .o_value(config_one)
    );

    current_b_reg16 #(
        .RESET_VALUE(current_b_pkg::RESET_CONFIG_TWO),
        .WRITE_MASK(current_b_pkg::MASK_CONFIG_TWO)
    ) u_config_two (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(wr_two),
        .i_data(i_reg_wdata),
        .o_value(config_two)
    );

    current_b_reg16 #(
        .RESET_VALUE(current_b_pkg::RESET_OFFSET),
        .WRITE_MASK(current_b_pkg::MASK_OFFSET_UPPER)
    ) u_offset_upper (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(wr_upper),
        .i_data(i_reg_wdata),
        .o_value(offset_upper)
    );

    current_b_reg16 #(
        .RESET_VALUE(current_b_pkg::RESET_OFFSET),
        .WRITE_MASK(current_b_pkg::MASK_OFFSET_LOWER)
    ) u_offset_lower (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(wr_lower),
        .i_data(i_reg_wdata),
        .o_value(offset_lower)
    );

    assign channel_active = config_two[current_b_pkg::BIT_CH_EN] && !i_standby && !i_power_down;

    // Ratio 64 is two to the sixth, so the code adds straight onto that exponent.
    assign osr_log2 = 5'(current_b_pkg::OSR_BASE_LOG2) + 5'(config_one[current_b_pkg::OSR_HI:current_b_pkg::OSR_LO]);
    assign chop_log2 = 5'(current_b_pkg::CHOP_BASE_LOG2) + 5'(config_one[current_b_pkg::CHOP_HI:current_b_pkg::CHOP_LO]);

    current_b_period_timer #(
        .LOG2_W(5)
    ) u_conv_timer (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_run(state.phase == CONVERT),
        .i_tick(i_mod_tick),
        .i_log2(osr_log2),
        .o_done(conv_done)
    );

    current_b_period_timer #(
        .LOG2_W(5)
    ) u_chop_timer (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_run(state.phase == CHOP_WAIT),
        .i_tick(i_mod_tick),
        .i_log2(chop_log2),
        .o_done(chop_done)
    );

    assign offset_value = {offset_upper,
        offset_lower[current_b_pkg::DATA_W-1:current_b_pkg::OFFSET_LOWER_LO]};
    // Offset is in result units at the selected gain, so it is removed after the digital gain step.
    assign gain_code = config_two[current_b_pkg::GAIN_HI:current_b_pkg::GAIN_LO];
    // Digital part of gains 16 and 32 is a left shift; the overflow wraps, as the analog stage saturates first.
    assign gained = (gain_code > current_b_pkg::GAIN_ANALOG_MAX) ?
        (i_raw_sample << (gain_code - current_b_pkg::GAIN_ANALOG_MAX)) : i_raw_sample;
    assign corrected = $signed(gained) - offset_value;

    always_comb begin
        next_state = state;
        next_state.result_valid = 1'b0;
        next_state.rvalid = i_reg_read;
        next_state.rdata = '0;
        case (i_reg_addr)
            current_b_pkg::ADDR_CONFIG_ONE: next_state.rdata = config_one;
            current_b_pkg::ADDR_CONFIG_TWO: next_state.rdata = config_two;
            current_b_pkg::ADDR_OFFSET_UPPER: next_state.rdata = offset_upper;
            current_b_pkg::ADDR_OFFSET_LOWER: next_state.rdata = offset_lower;
            default: next_state.rdata = '0;
        endcase
        if (!i_reg_read) begin
            next_state.rdata = '0;
        end
        next_state.channel_on = channel_active;
        next_state.single_shot = config_one[current_b_pkg::BIT_CONV_MODE];
        next_state.chop_on = config_one[current_b_pkg::BIT_CHOP_EN];
        next_state.analog_gain = (gain_code > current_b_pkg::GAIN_ANALOG_MAX) ?
            current_b_pkg::GAIN_ANALOG_MAX : gain_code;
        next_state.route = config_two[current_b_pkg::ROUTE_HI:current_b_pkg::ROUTE_LO];
        next_state.source_neg = config_two[current_b_pkg::BIT_SRC_ROUTE];
        next_state.sink_neg = config_two[current_b_pkg::BIT_SINK_ROUTE];
        next_state.source_mag = config_two[current_b_pkg::SRC_MAG_HI:current_b_pkg::SRC_MAG_LO];
        next_state.sink_mag = config_two[current_b_pkg::SINK_MAG_HI:current_b_pkg::SINK_MAG_LO];
        case (state.phase)
            IDLE: begin
                if (channel_active && (!config_one[current_b_pkg::BIT_CONV_MODE] || i_start)) begin
                    next_state.phase = CONVERT;
                end
            end
            CONVERT: begin
                if (conv_done) begin
                    next_state.result = corrected;
                    next_state.result_valid = 1'b1;
                    next_state.counter = state.counter + 2'h1;
                    if (config_one[current_b_pkg::BIT_CHOP_EN]) begin
                        next_state.chop_phase = !state.chop_phase;
                        next_state.phase = CHOP_WAIT;
                    end else if (config_one[current_b_pkg::BIT_CONV_MODE]) begin
                        next_state.phase = IDLE;
                    end
                end
            end
            CHOP_WAIT: begin
                if (chop_done) begin
                    next_state.phase = config_one[current_b_pkg::BIT_CONV_MODE] ? IDLE : CONVERT;
                end
            end
            default: next_state.phase = IDLE;
        endcase
        next_state.chop_settling = next_state.phase == CHOP_WAIT;
        if (!channel_active) begin
            next_state.phase = IDLE;
            next_state.chop_settling = 1'b0;
            next_state.result = '0;
            next_state.counter = '0;
            next_state.result_valid = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= '0;
            state.phase <= IDLE;
            state.channel_on <= current_b_pkg::RESET_CONFIG_TWO[current_b_pkg::BIT_CH_EN];
            state.sink_neg <= current_b_pkg::RESET_CONFIG_TWO[current_b_pkg::BIT_SINK_ROUTE];
        end else begin
            state <= next_state;
        end
    end

    assign o_reg_rdata = state.rdata;
    assign o_reg_rvalid = state.rvalid;
    assign o_channel_on = state.channel_on;
    assign o_single_shot = state.single_shot;
    assign o_chop_on = state.chop_on;
    assign o_chop_settling = state.chop_settling;
    assign o_analog_gain = state.analog_gain;
    assign o_route = state.route;
    assign o_source_on_negative = state.source_neg;
    assign o_sink_on_negative = state.sink_neg;
    assign o_source_magnitude = state.source_mag;
    assign o_sink_magnitude = state.sink_mag;
    assign o_result = state.result;
    assign o_result_valid = state.result_valid;
    assign o_conversion_counter = state.counter;
endmodule

/* common/current_b_pkg.sv */
// Constants for the current channel B configuration and calibration register set.
// Assumes a 16-bit register port with 8-bit addresses driven by the SPI front end.
// How it works
// - Bit 11 of config one picks continuous (0) or single-shot (1) conversions.
// - Bits 10:8 of config one pick oversampling 64 to 8192 by powers of two, reset 1024.
// - Without global chop, a result is produced once every oversampling-ratio modulator periods; chop adds the chop delay.
// - Bit 3 of config one enables global chop and resets to 0.
// - Bits 2:0 of config one set the chop delay to 2 shifted left by the code, in modulator periods.
// - Bit 15 of config two enables the channel and resets to 1.
// - A disabled channel, standby or power-down clears the result and the two-bit conversion counter.
// - Bits 11:10 of config two pick gain 4, 8, 16 or 32, with 16 and 32 done as analog 8 plus digital shift.
// - Bits 9:8 of config two route normal, swapped, shorted to ground, or the test DAC.
// - Bit 5 of config two steers the test source to the positive (0) or negative (1) pin, reset 0.
// - Bit 4 of config two steers the test sink to the positive (0) or negative (1) pin, reset 1.
// - Bits 3:2 of config two set the source current off, 4, 40 or 240 microamps.
// - Bits 1:0 of config two set the sink current with the same encoding.
// - The 24-bit offset sits as bits 23:8 in the upper register and bits 7:0 in bits 15:8 of the lower.
// - One offset step is twice the reference over gain times 2 to the 24.
package current_b_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] ADDR_CONFIG_ONE = 8'hc2;
    localparam logic [7:0] ADDR_CONFIG_TWO = 8'hc3;
    localparam logic [7:0] ADDR_OFFSET_UPPER = 8'hc4;
    localparam logic [7:0] ADDR_OFFSET_LOWER = 8'hc5;
    localparam logic [15:0] RESET_CONFIG_ONE = 16'h0400;
    localparam logic [15:0] RESET_CONFIG_TWO = 16'h8010;
    localparam logic [15:0] RESET_OFFSET = 16'h0000;
    localparam logic [15:0] MASK_CONFIG_ONE = 16'h0f0f;
    localparam logic [15:0] MASK_CONFIG_TWO = 16'h8f3f;
    localparam logic [15:0] MASK_OFFSET_UPPER = 16'hffff;
    localparam logic [15:0] MASK_OFFSET_LOWER = 16'hff00;
    localparam int BIT_CONV_MODE = 11;
    localparam int OSR_HI = 10;
    localparam int OSR_LO = 8;
    localparam int BIT_CHOP_EN = 3;
    localparam int CHOP_HI = 2;
    localparam int CHOP_LO = 0;
    localparam int BIT_CH_EN = 15;
    localparam int GAIN_HI = 11;
    localparam int GAIN_LO = 10;
    localparam int ROUTE_HI = 9;
    localparam int ROUTE_LO = 8;
    localparam int BIT_SRC_ROUTE = 5;
    localparam int BIT_SINK_ROUTE = 4;
    localparam int SRC_MAG_HI = 3;
    localparam int SRC_MAG_LO = 2;
    localparam int SINK_MAG_HI = 1;
    localparam int SINK_MAG_LO = 0;
    localparam int OFFSET_LOWER_LO = 8;
    localparam int OSR_BASE_LOG2 = 6;
    localparam int CHOP_BASE_LOG2 = 1;
    localparam int RESULT_W = 24;
    localparam int COUNT_W = 16;
    localparam logic [1:0] GAIN_ANALOG_MAX = 2'h1;
    localparam logic [1:0] ROUTE_NORMAL = 2'h0;
    localparam logic [1:0] ROUTE_SWAPPED = 2'h1;
    localparam logic [1:0] ROUTE_SHORTED = 2'h2;
    localparam logic [1:0] ROUTE_TEST_DAC = 2'h3;
endpackage

/* hdl/current_b_period_timer.sv */
// Counts modulator ticks and pulses when a programmable power-of-two period has elapsed.
// Assumes i_tick is a one-cycle strobe per modulator period.
module current_b_period_timer #(
    parameter int LOG2_W = 4
) (
    input wire logic i_clock, // System clock.
    input wire logic i_rst, // Synchronous reset, active high.
    input wire logic i_run, // Count while high, hold cleared while low.
    input wire logic i_tick, // Modulator period strobe.
    input wire logic [LOG2_W-1:0] i_log2, // Period as a power of two.
    output logic o_done // Pulse the cycle after the last tick of a period.
);
    localparam int CW = current_b_pkg::COUNT_W;
    typedef struct packed {
        logic [CW-1:0] count;
        logic done;
    } state_s;
    state_s state;
    state_s next_state;
    logic [CW-1:0] limit;

    initial begin
        if (LOG2_W < 1 || LOG2_W > 5) $error("LOG2_W out of range");
    end

    assign limit = CW'((32'h1 << i_log2) - 32'h1);

    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        if (!i_run) begin
            next_state.count = '0;
        end else if (i_tick) begin
            if (state.count == limit) begin
                next_state.count = '0;
                next_state.done = 1'b1;
            end else begin
                next_state.count = state.count + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_done = state.done;
endmodule

/* hdl/current_b_reg16.sv */
// One 16-bit configuration register with a writable-bit mask.
// Assumes writes are single-cycle strobes with a full 16-bit word.
module current_b_reg16 #(
    parameter logic [15:0] RESET_VALUE = 16'h0000,
    parameter logic [15:0] WRITE_MASK = 16'hffff
) (
    input wire logic i_clock, // System clock.
    input wire logic i_rst, // Synchronous reset, active high.
    input wire logic i_write, // Write strobe for this register.
    input wire logic [15:0] i_data, // Write data.
    output logic [15:0] o_value // Stored value, reserved bits zero.
);
    typedef struct packed {
        logic [15:0] value;
    } state_s;
    state_s state;
    state_s next_state;

    always_comb begin
        next_state = state;
        if (i_write) begin
            next_state.value = i_data & WRITE_MASK;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state.value <= RESET_VALUE & WRITE_MASK;
        end else begin
            state <= next_state;
        end
    end

    assign o_value = state.value;
endmodule

/* tb/current_b_config_regs_assertions.sv */
// Port-level checker for the current channel B register set.
// Assumes register strobes are single-cycle and at least two cycles apart.
module current_b_config_regs_checker (
    input wire logic i_clock, // System clock.
    input wire logic i_rst, // Synchronous reset.
    input wire logic i_reg_write, // Write strobe.
    input wire logic i_reg_read, // Read strobe.
    input wire logic [7:0] i_reg_addr, // Register address.
    input wire logic [15:0] i_reg_wdata, // Write data.
    input wire logic i_standby, // Standby level.
    input wire logic i_power_down, // Power-down level.
    input wire logic [15:0] o_reg_rdata, // Read data.
    input wire logic o_channel_on, // Channel running.
    input wire logic o_single_shot, // Single-shot mode.
    input wire logic o_chop_on, // Global chop on.
    input wire logic [1:0] o_analog_gain, // Analog gain code.
    input wire logic [1:0] o_route, // Input route code.
    input wire logic o_sink_on_negative, // Sink steering.
    input wire logic [23:0] o_result, // Conversion result.
    input wire logic o_result_valid, // New result pulse.
    input wire logic [1:0] o_conversion_counter // Conversion counter.
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    mode_bit_a: assert property (
        i_reg_write && i_reg_addr == 8'hc2 |-> ##2 o_single_shot == $past(i_reg_wdata[11], 2))
        else $error("conversion mode output does not follow its bit");
    chop_bit_a: assert property (
        i_reg_write && i_reg_addr == 8'hc2 |-> ##2 o_chop_on == $past(i_reg_wdata[3], 2))
        else $error("chop enable output does not follow its bit");
    route_field_a: assert property (
        i_reg_write && i_reg_addr == 8'hc3 |-> ##2 o_route == $past(i_reg_wdata[9:8], 2))
        else $error("input route output does not follow its field");
    sink_route_a: assert property (
        i_reg_write && i_reg_addr == 8'hc3 |-> ##2 o_sink_on_negative == $past(i_reg_wdata[4], 2))
        else $error("sink steering output does not follow its bit");
    gain_split_a: assert property (
        i_reg_write && i_reg_addr == 8'hc3 |-> ##2
        o_analog_gain == ($past(i_reg_wdata[11], 2) ? 2'h1 : {1'b0, $past(i_reg_wdata[10], 2)}))
        else $error("analog gain code is wrong");
    reserved_low_a: assert property (
        i_reg_read && i_reg_addr == 8'hc5 |=> o_reg_rdata[7:0] == 8'h00)
        else $error("reserved offset bits read nonzero");
    reserved_two_a: assert property (
        i_reg_read && i_reg_addr == 8'hc3 |=> o_reg_rdata[14:12] == 3'h0 && o_reg_rdata[7:6] == 2'h0)
        else $error("reserved config bits read nonzero");
    standby_off_a: assert property (
        i_standby || i_power_down |-> ##[1:2] !o_channel_on)
        else $error("channel stays on in a low-power state");
    clear_result_a: assert property (
        !o_channel_on |-> ##[0:1] (o_result == 24'h0 && o_conversion_counter == 2'h0))
        else $error("stopped channel keeps a result or count");
    valid_pulse_a: assert property (
        o_result_valid |=> !o_result_valid)
        else $error("result strobe longer than one cycle");
endmodule

bind current_b_config_regs current_b_config_regs_checker i_checker (.i_clock(i_clock), .i_rst(i_rst),
    .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_standby(i_standby), .i_power_down(i_power_down), .o_reg_rdata(o_reg_rdata), .o_channel_on(o_channel_on),
    .o_single_shot(o_single_shot), .o_chop_on(o_chop_on), .o_analog_gain(o_analog_gain), .o_route(o_route),
    .o_sink_on_negative(o_sink_on_negative), .o_result(o_result), .o_result_valid(o_result_valid),
    .o_conversion_counter(o_conversion_counter));

/* tb/current_b_host.sv */
// Host model that drives the decoded register port.
// Assumes strobes are taken on the rising edge, so it only moves signals on the falling edge.
module current_b_host (
    input wire logic i_clock, // System clock.
    input wire logic [15:0] i_reg_rdata, // Read data.
    input wire logic i_reg_rvalid, // Read data strobe.
    output logic o_reg_write, // Write strobe.
    output logic o_reg_read, // Read strobe.
    output logic [7:0] o_reg_addr, // Register address.
    output logic [15:0] o_reg_wdata // Write data.
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_reg_write = 1'b0;
        o_reg_read = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 16'h0000;
    end
    // Idle address and data are inverted so a stale value is never mistaken for a live one.
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        @(negedge i_clock);
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_write = 1'b1;
        @(negedge i_clock);
        o_reg_write = 1'b0;
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
    endtask
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        int n;
        @(negedge i_clock);
        o_reg_addr = a;
        o_reg_read = 1'b1;
        @(negedge i_clock);
        o_reg_read = 1'b0;
        o_reg_addr = ~a;
        n = 0;
        while (i_reg_rvalid !== 1'b1 && n < 4) begin
            @(negedge i_clock);
            n++;
        end
        d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 16'hxxxx;
    endtask
endmodule

/* tb/tb_current_b_config_regs.sv */
// Self-checking bench for the current channel B register set.
// Assumes the host model owns the register port; the bench drives every other input.
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t: got %h expected %h", $time, (a), (e)); end end
module tb_current_b_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_mod_tick = 1'b0;
    logic i_standby = 1'b0;
    logic i_power_down = 1'b0;
    logic i_start = 1'b0;
    logic [23:0] i_raw_sample = 24'h000100;
    logic i_reg_write, i_reg_read, o_reg_rvalid, o_channel_on, o_single_shot, o_chop_on, o_chop_settling;
    logic o_source_on_negative, o_sink_on_negative, o_result_valid;
    logic [7:0] i_reg_addr;
    logic [15:0] i_reg_wdata, o_reg_rdata, rd;
    logic [1:0] o_analog_gain, o_route, o_source_magnitude, o_sink_magnitude, o_conversion_counter;
    logic [23:0] o_result;
    int error_cnt = 0;
    int total_checks = 0;
    int tick_cnt = 0;
    int n, hits;
    initial begin
        forever #10 i_clock = ~i_clock;
    end
    // The modulator ticks once every four system clocks.
    always @(negedge i_clock) begin
        tick_cnt <= (tick_cnt + 1) % 4;
        i_mod_tick <= (tick_cnt == 3);
    end
    current_b_config_regs i_current_b_config_regs (.i_clock(i_clock), .i_rst(i_rst), .i_reg_write(i_reg_write),
        .i_reg_read(i_reg_read), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_mod_tick(i_mod_tick),
        .i_standby(i_standby), .i_power_down(i_power_down), .i_start(i_start), .i_raw_sample(i_raw_sample),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_channel_on(o_channel_on),
        .o_single_shot(o_single_shot), .o_chop_on(o_chop_on), .o_chop_settling(o_chop_settling),
        .o_analog_gain(o_analog_gain), .o_route(o_route), .o_source_on_negative(o_source_on_negative),
        .o_sink_on_negative(o_sink_on_negative), .o_source_magnitude(o_source_magnitude),
        .o_sink_magnitude(o_sink_magnitude), .o_result(o_result), .o_result_valid(o_result_valid),
        .o_conversion_counter(o_conversion_counter));
    current_b_host i_current_b_host (.i_clock(i_clock), .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid),
        .o_reg_write(i_reg_write), .o_reg_read(i_reg_read), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_current_b_host.write(a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        i_current_b_host.read(a, rd);
        `CHK(rd, e)
    endtask
    task automatic next_result(output int w);
        w = 0;
        do begin
            @(negedge i_clock);
            w++;
        end while (o_result_valid !== 1'b1 && w < 3000);
        `CHK(w < 3000, 1'b1)
    endtask
    // The first result after a change may straddle it, so only the second one is judged.
    task automatic conv(input int p, input logic [23:0] e);
        int w;
        next_result(w);
        next_result(w);
        `CHK(w, p)
        @(negedge i_clock);
        `CHK(o_result, e)
    endtask
    task automatic final_report();
        $display("checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #600000;
        error_cnt++;
        $display("[FAIL] %0t: watchdog expired", $time);
        final_report();
    end
    initial begin
        repeat (3) @(negedge i_clock);
        i_rst = 1'b0;
        rd_chk(8'hc2, 16'h0400);
        rd_chk(8'hc3, 16'h8010);
        rd_chk(8'hc4, 16'h0000);
        rd_chk(8'hc5, 16'h0000);
        rd_chk(8'hc6, 16'h0000);
        wr(8'hc2, 16'hffff);
        rd_chk(8'hc2, 16'h0f0f);
        wr(8'hc3, 16'hffff);
        rd_chk(8'hc3, 16'h8f3f);
        wr(8'hc5, 16'hffff);
        rd_chk(8'hc5, 16'hff00);
        for (int k = 0; k < 4; k++) begin
            wr(8'hc3, {4'h8, k[1:0], k[1:0], 2'b00, k[1], k[0], k[1:0], ~k[1:0]});
            repeat (3) @(negedge i_clock);
            `CHK(o_analog_gain, (k > 1) ? 2'h1 : k[1:0])
            `CHK(o_route, k[1:0])
            `CHK({o_source_on_negative, o_sink_on_negative}, k[1:0])
            `CHK({o_source_magnitude, o_sink_magnitude}, {k[1:0], ~k[1:0]})
        end
        wr(8'hc2, 16'h0000);
        wr(8'hc3, 16'h8000);
        wr(8'hc4, 16'h0000);
        wr(8'hc5, 16'h1000);
        conv(256, 24'h0000f0);
        wr(8'hc4, 16'hffff);
        wr(8'hc5, 16'hff00);
        conv(256, 24'h000101);
        wr(8'hc3, 16'h8800);
        conv(256, 24'h000201);
        wr(8'hc3, 16'h8c00);
        conv(256, 24'h000401);
        wr(8'hc2, 16'h0100);
        conv(512, 24'h000401);
        wr(8'hc2, 16'h000a);
        conv(288, 24'h000401);
        wr(8'hc2, 16'h000f);
        conv(1280, 24'h000401);
        next_result(n);
        `CHK(o_chop_settling, 1'b1)
        wr(8'hc3, 16'h0c00);
        repeat (3) @(negedge i_clock);
        `CHK({o_channel_on, o_result, o_conversion_counter}, 27'h0)
        wr(8'hc3, 16'h8c00);
        wr(8'hc2, 16'h0000);
        next_result(n);
        next_result(n);
        @(negedge i_clock);
        `CHK(o_conversion_counter, 2'h2)
        for (int m = 0; m < 2; m++) begin
            next_result(n);
            {i_power_down, i_standby} = (m == 1) ? 2'b10 : 2'b01;
            repeat (3) @(negedge i_clock);
            `CHK({o_result, o_conversion_counter}, 26'h0)
            {i_power_down, i_standby} = 2'b00;
        end
        wr(8'hc2, 16'h0800);
        repeat (600) @(negedge i_clock);
        hits = 0;
        repeat (300) begin
            @(negedge i_clock);
            if (o_result_valid === 1'b1) hits++;
        end
        `CHK(hits, 0)
        i_start = 1'b1;
        @(negedge i_clock);
        i_start = 1'b0;
        next_result(n);
        `CHK(n < 300, 1'b1)
        final_report();
    end
endmodule
